// ### verilog/amc_pkg.sv
package amc_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] ANC_CFG_ADDR = 8'h14;
  localparam logic [AW-1:0] MON_CFG_ADDR = 8'h15;
  localparam logic [AW-1:0] GEN_CFG_ADDR = 8'h17;
  localparam logic [AW-1:0] STATUS_ADDR = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] ANC_CFG_RST = 8'h00;
  localparam logic [DW-1:0] MON_CFG_RST = 8'h00;
  localparam logic [DW-1:0] GEN_CFG_RST = 8'h00;
  localparam logic [DW-1:0] ANC_CFG_MASK = 8'hFF;
  localparam logic [DW-1:0] MON_CFG_MASK = 8'hEF;
  localparam logic [DW-1:0] GEN_CFG_MASK = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SRC_SEL_HI = 7;
  localparam int SRC_SEL_LO = 6;
  localparam int ANC_SILENCE_BIT = 5;
  localparam int ANC_MIX_BIT = 4;
  localparam int ANC_OP2L_BIT = 3;
  localparam int ANC_OP2R_BIT = 2;
  localparam int ANC_OP1L_BIT = 1;
  localparam int ANC_OP1R_BIT = 0;
  localparam int MON_SILENCE_BIT = 6;
  localparam int MON_MIX_BIT = 5;
  localparam int MON_ATT_HI = 3;
  localparam int MON_ATT_LO = 2;
  localparam int MON_SLIDER_BIT = 1;
  localparam int MON_DISABLE_BIT = 0;
  localparam int GEN_SLIDE_PWR_BIT = 7;
  localparam int STAT_OVERLAP_BIT = 0;
  localparam int STAT_ROUTE_LO = 1;
  localparam int STAT_ROUTE_HI = 2;
  localparam int STAT_SLIDER_ERR_BIT = 3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AMC_SRC_MIC = 2'b00,
    AMC_SRC_FIRST = 2'b01,
    AMC_SRC_SECOND = 2'b10,
    AMC_SRC_NONE = 2'b11
  } amc_src_e;

  typedef enum logic [1:0] {
    AMC_ATT_0DB = 2'b00,
    AMC_ATT_M24DB = 2'b01,
    AMC_ATT_M30DB = 2'b10,
    AMC_ATT_M36DB = 2'b11
  } amc_att_e;

  typedef enum logic [1:0] {
    AMC_ROUTE_IDLE = 2'b00,
    AMC_ROUTE_ANC = 2'b01,
    AMC_ROUTE_MON = 2'b10,
    AMC_ROUTE_PBO = 2'b11
  } amc_route_e;

endpackage

// ### verilog/amc_src_if.sv
// Source selector code out, one-hot routing switches back
interface amc_src_if;
  logic [1:0] sel;
  logic mic;
  logic first_amp;
  logic second_amp;

  modport ctrl (
    output sel,
    input mic,
    input first_amp,
    input second_amp
  );

  modport dec (
    input sel,
    output mic,
    output first_amp,
    output second_amp
  );
endinterface

// ### verilog/amc_src_decode.sv
module amc_src_decode (
  amc_src_if.dec src
);
  import amc_pkg::*;

  // ----------------------------------------------------------------
  // Selector to one-hot switch decode
  // ----------------------------------------------------------------
  // Code 11 opens every switch so no source reaches the amplifier
  always_comb
  begin
    src.mic = 1'b0;
    src.first_amp = 1'b0;
    src.second_amp = 1'b0;
    unique case (amc_src_e'(src.sel))
      AMC_SRC_MIC: src.mic = 1'b1;
      AMC_SRC_FIRST: src.first_amp = 1'b1;
      AMC_SRC_SECOND: src.second_amp = 1'b1;
      AMC_SRC_NONE: ;
    endcase
  end
endmodule

// ### verilog/amc_regs.sv
// How it works
// - ANC route: bit 5 set cuts line input from headphone amplifier.
// - ANC route: bit 4 set enables headphone mixer input pin.
// - ANC route: bit 3 switches second op-amp left channel.
// - ANC route: bit 2 switches second op-amp right channel.
// - ANC route: bit 1 switches first op-amp left channel.
// - ANC route: bit 0 switches first op-amp right channel.
// - Monitor route: bits 7:6 pick mic, op-amp one, op-amp two or nothing.
// - Monitor route: monitor bit 6 set cuts line input from amplifier.
// - Monitor bit 5 enables mixer input pin in playback route.
// - Monitor bits 3:2 set line gain 0, -24, -30 or -36 dB.
// - Monitor bit 1 picks ordinary or full slider configuration.
// - Push-button control: monitor bit 0 set suppresses monitor route.
// - General register bit 7 enables slide-switch power up and down.
// - ANC route: ANC bits 7:6 pick the amplifier source.
//
// Our own choice: the plain strobed port.
module amc_regs (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [amc_pkg::AW-1:0] addr,
  input wire logic [amc_pkg::DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [amc_pkg::DW-1:0] rd_data,
  input wire logic anc_path_config_req,
  input wire logic monitor_mode_req,
  input wire logic playback_mode_req,
  input wire logic push_button_ctrl,
  output logic line_input_silence,
  output logic headphone_mixer_pin_on,
  output logic anc_second_opamp_left_on,
  output logic anc_second_opamp_right_on,
  output logic anc_first_opamp_left_on,
  output logic anc_first_opamp_right_on,
  output logic mic_preamp_out_to_hp,
  output logic first_opamp_to_hp,
  output logic second_opamp_to_hp,
  output logic [1:0] monitor_line_attenuation,
  output logic full_slider_select,
  output logic slide_switch_power_ctrl,
  output logic monitor_bit6_overlap,
  output logic [1:0] active_route
);
  import amc_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DW-1:0] anc_path_config;
  logic [DW-1:0] monitor_path_config;
  logic [DW-1:0] gen_config;
  logic slider_order_err;
  amc_route_e route;
  amc_route_e next_route;
  logic monitor_permitted;
  logic [DW-1:0] next_rd_data;
  logic [DW-1:0] status_word;

  amc_src_if anc_src ();
  amc_src_if mon_src ();

  // Byte write helper: only writable bits change, reserved bits stay zero
  function automatic logic [DW-1:0] masked_write(input logic [DW-1:0] old_val,
                                                  input logic [DW-1:0] new_val,
                                                  input logic [DW-1:0] mask);
    masked_write = (old_val & ~mask) | (new_val & mask);
  endfunction

  // Address hit helper, shared by write and read decode
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] target);
    hit = (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // ANC path register; selector, silence, mixer and op-amp fields
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      anc_path_config <= ANC_CFG_RST;
    else if (ce && wr_en && hit(addr, ANC_CFG_ADDR))
      anc_path_config <= masked_write(anc_path_config, wr_data, ANC_CFG_MASK);
  end

  // Monitor path register; bit 4 is reserved and reads zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      monitor_path_config <= MON_CFG_RST;
    else if (ce && wr_en && hit(addr, MON_CFG_ADDR))
      monitor_path_config <= masked_write(monitor_path_config, wr_data, MON_CFG_MASK);
  end

  // General settings; only the slide power enable lives in this block
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      gen_config <= GEN_CFG_RST;
    else if (ce && wr_en && hit(addr, GEN_CFG_ADDR))
      gen_config <= masked_write(gen_config, wr_data, GEN_CFG_MASK);
  end

  // ----------------------------------------------------------------
  // Slider ordering watch
  // ----------------------------------------------------------------
  // Sticky flag when full slider is on without slide power; the new
  // violation wins over the clear in the same cycle. Cleared by a
  // write of one to its status bit. Hardware does not block the
  // setting, since ordering is the driver's duty.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      slider_order_err <= 1'b0;
    else if (ce)
    begin
      if (monitor_path_config[MON_SLIDER_BIT] && !gen_config[GEN_SLIDE_PWR_BIT])
        slider_order_err <= 1'b1;
      else if (wr_en && hit(addr, STATUS_ADDR) && wr_data[STAT_SLIDER_ERR_BIT])
        slider_order_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Route selection
  // ----------------------------------------------------------------
  // Push-button control may veto monitor mode
  assign monitor_permitted = !(push_button_ctrl && monitor_path_config[MON_DISABLE_BIT]);

  // ANC wins over monitor, monitor over playback
  always_comb
  begin
    if (anc_path_config_req)
      next_route = AMC_ROUTE_ANC;
    else if (monitor_mode_req && monitor_permitted)
      next_route = AMC_ROUTE_MON;
    else if (playback_mode_req)
      next_route = AMC_ROUTE_PBO;
    else
      next_route = AMC_ROUTE_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      route <= AMC_ROUTE_IDLE;
    else if (ce)
      route <= next_route;
  end

  // ----------------------------------------------------------------
  // Source selector decode
  // ----------------------------------------------------------------
  // One decoder per register so both selectors are always live
  assign anc_src.sel = anc_path_config[SRC_SEL_HI:SRC_SEL_LO];
  assign mon_src.sel = monitor_path_config[SRC_SEL_HI:SRC_SEL_LO];

  amc_src_decode u_anc_dec (
    .src(anc_src.dec)
  );

  amc_src_decode u_mon_dec (
    .src(mon_src.dec)
  );

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  // Registered so the analog switches see glitch-free levels; they
  // follow the route one cycle after it settles.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_input_silence <= 1'b0;
      headphone_mixer_pin_on <= 1'b0;
      anc_second_opamp_left_on <= 1'b0;
      anc_second_opamp_right_on <= 1'b0;
      anc_first_opamp_left_on <= 1'b0;
      anc_first_opamp_right_on <= 1'b0;
      mic_preamp_out_to_hp <= 1'b0;
      first_opamp_to_hp <= 1'b0;
      second_opamp_to_hp <= 1'b0;
      monitor_line_attenuation <= AMC_ATT_0DB;
    end
    else if (ce)
    begin
      line_input_silence <= 1'b0;
      headphone_mixer_pin_on <= 1'b0;
      anc_second_opamp_left_on <= 1'b0;
      anc_second_opamp_right_on <= 1'b0;
      anc_first_opamp_left_on <= 1'b0;
      anc_first_opamp_right_on <= 1'b0;
      mic_preamp_out_to_hp <= 1'b0;
      first_opamp_to_hp <= 1'b0;
      second_opamp_to_hp <= 1'b0;
      monitor_line_attenuation <= AMC_ATT_0DB;
      unique case (route)
        AMC_ROUTE_ANC:
        begin
          line_input_silence <= anc_path_config[ANC_SILENCE_BIT];
          headphone_mixer_pin_on <= anc_path_config[ANC_MIX_BIT];
          anc_second_opamp_left_on <= anc_path_config[ANC_OP2L_BIT];
          anc_second_opamp_right_on <= anc_path_config[ANC_OP2R_BIT];
          anc_first_opamp_left_on <= anc_path_config[ANC_OP1L_BIT];
          anc_first_opamp_right_on <= anc_path_config[ANC_OP1R_BIT];
          mic_preamp_out_to_hp <= anc_src.mic;
          first_opamp_to_hp <= anc_src.first_amp;
          second_opamp_to_hp <= anc_src.second_amp;
        end
        AMC_ROUTE_MON:
        begin
          // Bit 6 drives both the mute and the selector's low bit
          line_input_silence <= monitor_path_config[MON_SILENCE_BIT];
          headphone_mixer_pin_on <= monitor_path_config[MON_MIX_BIT];
          mic_preamp_out_to_hp <= mon_src.mic;
          first_opamp_to_hp <= mon_src.first_amp;
          second_opamp_to_hp <= mon_src.second_amp;
          monitor_line_attenuation <= monitor_path_config[MON_ATT_HI:MON_ATT_LO];
        end
        AMC_ROUTE_PBO:
          headphone_mixer_pin_on <= monitor_path_config[MON_MIX_BIT];
        AMC_ROUTE_IDLE: ;
      endcase
    end
  end

  // Mode-independent controls straight from the registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      full_slider_select <= 1'b0;
      slide_switch_power_ctrl <= 1'b0;
      monitor_bit6_overlap <= 1'b0;
      active_route <= AMC_ROUTE_IDLE;
    end
    else if (ce)
    begin
      full_slider_select <= monitor_path_config[MON_SLIDER_BIT];
      slide_switch_power_ctrl <= gen_config[GEN_SLIDE_PWR_BIT];
      // Raised whenever bit 6 means two things at once
      monitor_bit6_overlap <= monitor_path_config[MON_SILENCE_BIT];
      active_route <= route;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    status_word = '0;
    status_word[STAT_OVERLAP_BIT] = monitor_path_config[MON_SILENCE_BIT];
    status_word[STAT_ROUTE_HI:STAT_ROUTE_LO] = route;
    status_word[STAT_SLIDER_ERR_BIT] = slider_order_err;
  end

  // Unmapped addresses read as zero
  always_comb
  begin
    next_rd_data = '0;
    if (hit(addr, ANC_CFG_ADDR))
      next_rd_data = anc_path_config;
    else if (hit(addr, MON_CFG_ADDR))
      next_rd_data = monitor_path_config;
    else if (hit(addr, GEN_CFG_ADDR))
      next_rd_data = gen_config;
    else if (hit(addr, STATUS_ADDR))
      next_rd_data = status_word;
  end

  // Data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= '0;
    else if (ce)
      rd_data <= rd_en ? next_rd_data : '0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_anc_write(logic [DW-1:0] d);
    ce && wr_en && addr == ANC_CFG_ADDR && wr_data == d;
  endsequence

  sequence s_route_is(amc_route_e r);
    ce && route == r;
  endsequence

  // Reserved bits never leave zero, so the masked write data is the whole value
  property p_readback(logic [AW-1:0] a, logic [DW-1:0] m);
    (ce && wr_en && addr == a) ##1 (ce && rd_en && addr == a)
      |=> rd_data == ($past(wr_data, 2) & m);
  endproperty

  a_anc_readback: assert property (p_readback(ANC_CFG_ADDR, ANC_CFG_MASK))
    else $error("ANC path register read back differs from last write");

  a_mon_readback: assert property (p_readback(MON_CFG_ADDR, MON_CFG_MASK))
    else $error("Monitor path register read back differs from last write");

  a_anc_silence_follow: assert property (
    s_route_is(AMC_ROUTE_ANC) |=> line_input_silence == $past(anc_path_config[ANC_SILENCE_BIT]))
    else $error("Line silence does not follow ANC bit 5");

  a_anc_mixer_follow: assert property (
    s_route_is(AMC_ROUTE_ANC) |=> headphone_mixer_pin_on == $past(anc_path_config[ANC_MIX_BIT]))
    else $error("Mixer pin does not follow ANC bit 4");

  a_anc_opamp_follow: assert property (
    s_route_is(AMC_ROUTE_ANC) |=> {anc_second_opamp_left_on, anc_second_opamp_right_on,
      anc_first_opamp_left_on, anc_first_opamp_right_on} == $past(anc_path_config[3:0]))
    else $error("Op-amp enables do not follow ANC bits 3 to 0");

  a_anc_write_pins: assert property (
    s_anc_write(8'h01) ##1 (ce && anc_path_config_req && !wr_en)[*2] |=> anc_first_opamp_right_on &&
      !anc_first_opamp_left_on && mic_preamp_out_to_hp)
    else $error("ANC write did not reach the op-amp pins in three cycles");

  a_mon_source_route: assert property (
    s_route_is(AMC_ROUTE_MON) ##0 monitor_path_config[7:6] == 2'b11 |=>
      !mic_preamp_out_to_hp && !first_opamp_to_hp && !second_opamp_to_hp)
    else $error("Monitor selector code 11 left a source connected");

  a_mon_silence_follow: assert property (
    s_route_is(AMC_ROUTE_MON) |=> line_input_silence == $past(monitor_path_config[6]))
    else $error("Monitor line silence does not follow bit 6");

  a_pbo_mixer_follow: assert property (
    s_route_is(AMC_ROUTE_PBO) |=> headphone_mixer_pin_on == $past(monitor_path_config[5]))
    else $error("Playback mixer pin does not follow monitor bit 5");

  a_mon_atten_follow: assert property (
    s_route_is(AMC_ROUTE_MON) |=> monitor_line_attenuation == $past(monitor_path_config[3:2]))
    else $error("Line attenuation does not follow monitor bits 3 to 2");

  a_slider_follow: assert property (
    ce |=> full_slider_select == $past(monitor_path_config[MON_SLIDER_BIT]))
    else $error("Full slider output does not follow monitor bit 1");

  a_monitor_veto: assert property (
    ce && push_button_ctrl && monitor_path_config[0] && !anc_path_config_req |=>
      route != AMC_ROUTE_MON)
    else $error("Monitor route entered while disabled under push-button control");

  a_slide_power: assert property (
    ce |=> slide_switch_power_ctrl == $past(gen_config[GEN_SLIDE_PWR_BIT]))
    else $error("Slide power control does not follow general bit 7");

  a_overlap_flag: assert property (
    ce && monitor_path_config[MON_SILENCE_BIT] |=> monitor_bit6_overlap)
    else $error("Bit 6 overlap not flagged");

  a_rd_idle_zero: assert property (
    !rd_en ##1 1'b1 |-> rd_data == '0 || !$past(ce))
    else $error("Read data present without a read strobe");

endmodule

// ### verif/amc_regs_tb_top.sv
module amc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import amc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [AW-1:0] addr = 8'h00;
  logic [DW-1:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DW-1:0] rd_data;
  logic anc_req = 1'b0;
  logic mon_req = 1'b0;
  logic pbo_req = 1'b0;
  logic push_btn = 1'b0;
  logic sil, mix, op2l, op2r, op1l, op1r, src_mic, src_first, src_second, fs, sp, ov;
  logic [1:0] att;
  logic [1:0] route;
  logic [15:0] pins;
  int miscompares = 0;
  int checked = 0;

  // Pack every routing output into one word so one compare covers them
  assign pins = {sil, mix, op2l, op2r, op1l, op1r, src_mic, src_first, src_second, att, fs, sp,
    ov, route};

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  amc_regs uut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .anc_path_config_req(anc_req),
    .monitor_mode_req(mon_req),
    .playback_mode_req(pbo_req),
    .push_button_ctrl(push_btn),
    .line_input_silence(sil),
    .headphone_mixer_pin_on(mix),
    .anc_second_opamp_left_on(op2l),
    .anc_second_opamp_right_on(op2r),
    .anc_first_opamp_left_on(op1l),
    .anc_first_opamp_right_on(op1r),
    .mic_preamp_out_to_hp(src_mic),
    .first_opamp_to_hp(src_first),
    .second_opamp_to_hp(src_second),
    .monitor_line_attenuation(att),
    .full_slider_select(fs),
    .slide_switch_power_ctrl(sp),
    .monitor_bit6_overlap(ov),
    .active_route(route)
  );

  // ----------------------------------------------------------------
  // Reporting and checks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t read got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Masked so routes with loosely defined outputs only judge what is known
  task automatic chk_pins(input logic [15:0] exp, input logic [15:0] mask);
    checked++;
    if ((pins & mask) !== (exp & mask))
    begin
      miscompares++;
      $display("MISMATCH t=%0t pins got=%h exp=%h", $time, pins & mask, exp & mask);
    end
  endtask

  function automatic logic [15:0] pk(logic s, logic m, logic [3:0] ops, logic [2:0] src,
    logic [1:0] a, logic f, logic p, logic o, logic [1:0] r);
    return {s, m, ops, src, a, f, p, o, r};
  endfunction

  // One-hot order is mic, op-amp one, op-amp two; code 11 selects none
  function automatic logic [2:0] src_oh(logic [1:0] c);
    return (c == 2'b11) ? 3'b000 : (3'b100 >> c);
  endfunction

  // ----------------------------------------------------------------
  // Bus and mode drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk_rd(rd_data, exp);
  endtask

  // Write then read the same address with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk_rd(rd_data, exp);
  endtask

  // Outputs follow a register or mode change within two edges
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic set_mode(input logic a, input logic m, input logic p, input logic b);
    @(posedge sys_clk);
    anc_req <= a;
    mon_req <= m;
    pbo_req <= p;
    push_btn <= b;
    settle();
  endtask

  // Mode inputs drop with reset so the route reads idle afterwards
  task automatic do_reset();
    @(posedge sys_clk);
    rstn <= 1'b0;
    anc_req <= 1'b0;
    mon_req <= 1'b0;
    pbo_req <= 1'b0;
    push_btn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    #1;
    chk_pins(16'h0000, 16'hFFFF);
    rd_chk(ANC_CFG_ADDR, ANC_CFG_RST);
    rd_chk(MON_CFG_ADDR, MON_CFG_RST);
    rd_chk(GEN_CFG_ADDR, GEN_CFG_RST);
    rd_chk(STATUS_ADDR, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("test reset done");
  endtask

  // Every selector code with mixed enable patterns; code 00 lights one op-amp alone
  task automatic t_anc();
    logic [5:0] pat [4] = '{6'b000001, 6'b010101, 6'b111111, 6'b000000};
    logic [7:0] v;
    set_mode(1'b1, 1'b0, 1'b0, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      v = {c[1:0], pat[c]};
      wr(ANC_CFG_ADDR, v);
      settle();
      chk_pins(pk(v[5], v[4], v[3:0], src_oh(c[1:0]), 2'b00, 1'b0, 1'b0, 1'b0, AMC_ROUTE_ANC),
        16'hFFFF);
      rd_chk(ANC_CFG_ADDR, v);
    end
    $display("test anc done");
  endtask

  // Reserved bit 4 is written high and must read back low
  task automatic t_mon();
    logic [7:0] v;
    set_mode(1'b0, 1'b1, 1'b0, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      v = {c[1:0], c[1], 1'b1, c[1:0], 2'b00};
      wr(MON_CFG_ADDR, v);
      settle();
      chk_pins(pk(c[0], c[1], 4'h0, src_oh(c[1:0]), c[1:0], 1'b0, 1'b0, c[0], AMC_ROUTE_MON),
        16'hFFFF);
      rd_chk(MON_CFG_ADDR, v & MON_CFG_MASK);
    end
    rd_chk(STATUS_ADDR, 8'h05);
    $display("test monitor done");
  endtask

  task automatic t_pbo();
    wr(MON_CFG_ADDR, 8'h20);
    set_mode(1'b0, 1'b0, 1'b1, 1'b0);
    chk_pins(pk(1'b0, 1'b1, 4'h0, 3'h0, 2'b00, 1'b0, 1'b0, 1'b0, AMC_ROUTE_PBO), 16'h4003);
    wr(MON_CFG_ADDR, 8'h00);
    settle();
    chk_pins(16'h0003, 16'h4003);
    $display("test playback done");
  endtask

  // Full slider before slide power leaves a sticky flag until cleared
  task automatic t_slider();
    set_mode(1'b0, 1'b0, 1'b0, 1'b0);
    wr_rd(MON_CFG_ADDR, 8'h12, 8'h02);
    settle();
    chk_pins(16'h0010, 16'h0018);
    rd_chk(STATUS_ADDR, 8'h08);
    wr(MON_CFG_ADDR, 8'h00);
    rd_chk(STATUS_ADDR, 8'h08);
    wr(STATUS_ADDR, 8'h08);
    rd_chk(STATUS_ADDR, 8'h00);
    wr(GEN_CFG_ADDR, 8'hFF);
    rd_chk(GEN_CFG_ADDR, 8'hFF & GEN_CFG_MASK);
    wr(MON_CFG_ADDR, 8'h02);
    settle();
    chk_pins(16'h0018, 16'h0018);
    rd_chk(STATUS_ADDR, 8'h00);
    $display("test slider done");
  endtask

  task automatic t_push();
    wr(MON_CFG_ADDR, 8'h01);
    set_mode(1'b0, 1'b1, 1'b0, 1'b1);
    chk_pins(16'h0000, 16'h0003);
    wr(MON_CFG_ADDR, 8'h00);
    settle();
    settle();
    chk_pins(16'h0002, 16'h0003);
    wr(MON_CFG_ADDR, 8'h01);
    set_mode(1'b0, 1'b1, 1'b0, 1'b0);
    settle();
    chk_pins(16'h0002, 16'h0003);
    $display("test push button done");
  endtask

  // A frozen clock enable must swallow writes; unmapped writes leave no trace
  task automatic t_ce();
    wr_rd(ANC_CFG_ADDR, 8'h11, 8'h11);
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(ANC_CFG_ADDR, 8'hEE);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd_chk(ANC_CFG_ADDR, 8'h11);
    wr(8'h20, 8'hA5);
    rd_chk(8'h20, 8'h00);
    $display("test clock enable done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    t_reset();
    t_anc();
    t_mon();
    t_pbo();
    t_slider();
    t_push();
    t_ce();
    do_reset();
    t_reset();
    stop_test();
  end

  initial
  begin
    #800000;
    miscompares++;
    stop_test();
  end
endmodule
